/* include/cvr_consts.vh */
`ifndef CVR_CONSTS_VH
`define CVR_CONSTS_VH
// Register byte addresses on the APB.
`define CVR_ADDR_CMP_CTL   12'h000
`define CVR_ADDR_REF_CTL   12'h004
`define CVR_ADDR_FLAGS2    12'h008
`define CVR_ADDR_ENABLES2  12'h00C
`define CVR_ADDR_MASTER    12'h010
`define CVR_ADDR_ANACFG    12'h014
// Comparator control fields.
`define CVR_CMP_RES_B      7
`define CVR_CMP_RES_A      6
`define CVR_CMP_INV_B      5
`define CVR_CMP_INV_A      4
`define CVR_CMP_SWITCH     3
`define CVR_CMP_MODE_HI    2
`define CVR_CMP_CTL_RST    6'h07
`define CVR_MODE_OFF       3'h7
// Reference control fields.
`define CVR_REF_PWR        7
`define CVR_REF_PINOE      6
`define CVR_REF_RANGE      5
`define CVR_REF_SRC        4
`define CVR_REF_RST        8'h00
// Flag and enable bit positions.
`define CVR_FLAG_BIT       6
`define CVR_MASTER_GLOBAL  7
`define CVR_MASTER_PERIPH  6
`define CVR_ANACFG_RST     4'h0
`define CVR_ANACFG_HI      3
// Field tops, idle read word and plain bit reset level.
`define CVR_LEVEL_HI       3
`define CVR_LEVEL_RST      4'h0
`define CVR_DATA_HI        31
`define CVR_RD_IDLE        32'h0000_0000
`define CVR_BIT_RST        1'b0
`endif

/* rtl/cvr_comparator_ctrl.v */
// Functional notes
// - Output change on either comparator sets flag.
// - Comparator results readable in control bits 7:6.
// - Flag at bit 6, cleared only by software.
// - Writing one to flag sets it.
// - Request needs flag and three enables.
// - Flag sets even with enables clear.
// - Change during control read may be missed.
// - Control register access relatches outputs.
// - Mismatch keeps setting flag until relatched.
// - Comparators and interrupt work in sleep; wake.
// - Waking leaves comparator control unchanged.
// - Reset selects mode 111, comparators off.
// - Comparator pins analog after reset, follow config.
// - Range bit 5 chooses between two ranges.
// - Range one: level over 24 of source.
// - Range zero: quarter plus level over 32.
// - Bit 4 chooses external pins or supply.
// - Bit 7 powers ladder on or down.
// - Bit 6 routes level to pin, overriding direction.
// - Level code 0 to 15 selects tap.
// - Bits 5 and 4 invert comparator polarity.
// - Reset clears reference control register.
`timescale 1ns/1ps
`include "cvr_consts.vh"
module cvr_comparator_ctrl (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        cmpARaw,
   input  wire        cmpBRaw,
   input  wire        sleepMode,
   output reg  [2:0]  cmpModeSel,
   output reg         cmpInputSwitch,
   output reg         ladderPowerEn,
   output reg         ladderPinOutEn,
   output reg         ladderRangeSel,
   output reg         ladderSourceSel,
   output reg  [3:0]  ladderLevelCode,
   output reg  [3:0]  pinAnalogCfg,
   output reg         cmpIrqReq,
   output reg         wakeReq
);

   wire                      syncA;
   wire                      syncB;
   wire                      resA;
   wire                      resB;
   wire                      access;
   wire                      wr;
   wire                      rdAcc;
   wire                      cmpAccess;
   wire                      cmpWr;
   wire                      refWr;
   wire                      flagWr;
   wire                      mismatchA;
   wire                      mismatchB;
   wire                      mismatch;
   wire                      irqAll;
   wire                      wakeAll;
   reg                       latA_r;
   reg                       latB_r;
   reg                       invA_r;
   reg                       invB_r;
   reg                       inSwitch_r;
   reg  [`CVR_CMP_MODE_HI:0] mode_r;
   reg                       refPwr_r;
   reg                       refPinOe_r;
   reg                       refRange_r;
   reg                       refSrc_r;
   reg  [`CVR_LEVEL_HI:0]    refLevel_r;
   reg                       flag_r;
   reg                       flagEn_r;
   reg                       globalEn_r;
   reg                       periphEn_r;
   reg                       flag_nxt;
   reg  [`CVR_DATA_HI:0]     rd_nxt;
   reg                       err_nxt;

   // Two-stage synchronisers; only the last stage is ever read.
   cvr_sync2 #(
      .WIDTH (1)
   ) u_syncA (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (cmpARaw),
      .dout  (syncA)
   );

   cvr_sync2 #(
      .WIDTH (1)
   ) u_syncB (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (cmpBRaw),
      .dout  (syncB)
   );

   assign resA      = syncA ^ invA_r;
   assign resB      = syncB ^ invB_r;
   assign access    = psel & penable & ~pready;
   assign wr        = access & pwrite;
   assign rdAcc     = access & ~pwrite;
   assign cmpAccess = access & (paddr == `CVR_ADDR_CMP_CTL);
   assign cmpWr     = cmpAccess & pwrite;
   assign refWr     = wr & (paddr == `CVR_ADDR_REF_CTL);
   assign flagWr    = wr & (paddr == `CVR_ADDR_FLAGS2);
   assign mismatchA = resA ^ latA_r;
   assign mismatchB = resB ^ latB_r;
   assign mismatch  = mismatchA | mismatchB;
   assign irqAll    = flag_r & flagEn_r & periphEn_r & globalEn_r;
   assign wakeAll   = sleepMode & flag_r & flagEn_r;

   // A live mismatch or a written one beats a software clear in the same cycle.
   // The edge that relatches the outputs does not set the flag as well.
   always @* begin
      flag_nxt = flag_r;
      if (flagWr) begin
         flag_nxt = pwdata[`CVR_FLAG_BIT];
      end
      if (mismatch && !cmpAccess) begin
         flag_nxt = 1'b1;
      end
   end

   always @* begin
      rd_nxt  = `CVR_RD_IDLE;
      err_nxt = 1'b0;
      case (paddr)
         `CVR_ADDR_CMP_CTL: begin
            rd_nxt[`CVR_CMP_RES_B]     = resB;
            rd_nxt[`CVR_CMP_RES_A]     = resA;
            rd_nxt[`CVR_CMP_INV_B]     = invB_r;
            rd_nxt[`CVR_CMP_INV_A]     = invA_r;
            rd_nxt[`CVR_CMP_SWITCH]    = inSwitch_r;
            rd_nxt[`CVR_CMP_MODE_HI:0] = mode_r;
         end
         `CVR_ADDR_REF_CTL: begin
            rd_nxt[`CVR_REF_PWR]    = refPwr_r;
            rd_nxt[`CVR_REF_PINOE]  = refPinOe_r;
            rd_nxt[`CVR_REF_RANGE]  = refRange_r;
            rd_nxt[`CVR_REF_SRC]    = refSrc_r;
            rd_nxt[`CVR_LEVEL_HI:0] = refLevel_r;
         end
         `CVR_ADDR_FLAGS2: begin
            rd_nxt[`CVR_FLAG_BIT] = flag_r;
         end
         `CVR_ADDR_ENABLES2: begin
            rd_nxt[`CVR_FLAG_BIT] = flagEn_r;
         end
         `CVR_ADDR_MASTER: begin
            rd_nxt[`CVR_MASTER_GLOBAL] = globalEn_r;
            rd_nxt[`CVR_MASTER_PERIPH] = periphEn_r;
         end
         `CVR_ADDR_ANACFG: begin
            rd_nxt[`CVR_ANACFG_HI:0] = pinAnalogCfg;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   // Every access is answered one clock after it is taken.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= `CVR_BIT_RST;
         pslverr <= `CVR_BIT_RST;
      end else begin
         pready  <= access;
         pslverr <= access & err_nxt;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= `CVR_RD_IDLE;
      end else if (rdAcc) begin
         prdata <= rd_nxt;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latA_r <= `CVR_BIT_RST;
      end else if (cmpAccess) begin
         latA_r <= resA;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latB_r <= `CVR_BIT_RST;
      end else if (cmpAccess) begin
         latB_r <= resB;
      end
   end

   // Sleep never touches these fields, so waking finds them as they were left.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         invA_r <= `CVR_BIT_RST;
      end else if (cmpWr) begin
         invA_r <= pwdata[`CVR_CMP_INV_A];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         invB_r <= `CVR_BIT_RST;
      end else if (cmpWr) begin
         invB_r <= pwdata[`CVR_CMP_INV_B];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         inSwitch_r <= `CVR_BIT_RST;
      end else if (cmpWr) begin
         inSwitch_r <= pwdata[`CVR_CMP_SWITCH];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= `CVR_MODE_OFF;
      end else if (cmpWr) begin
         mode_r <= pwdata[`CVR_CMP_MODE_HI:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refPwr_r <= `CVR_BIT_RST;
      end else if (refWr) begin
         refPwr_r <= pwdata[`CVR_REF_PWR];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refPinOe_r <= `CVR_BIT_RST;
      end else if (refWr) begin
         refPinOe_r <= pwdata[`CVR_REF_PINOE];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refRange_r <= `CVR_BIT_RST;
      end else if (refWr) begin
         refRange_r <= pwdata[`CVR_REF_RANGE];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refSrc_r <= `CVR_BIT_RST;
      end else if (refWr) begin
         refSrc_r <= pwdata[`CVR_REF_SRC];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refLevel_r <= `CVR_LEVEL_RST;
      end else if (refWr) begin
         refLevel_r <= pwdata[`CVR_LEVEL_HI:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flagEn_r <= `CVR_BIT_RST;
      end else if (wr && paddr == `CVR_ADDR_ENABLES2) begin
         flagEn_r <= pwdata[`CVR_FLAG_BIT];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         globalEn_r <= `CVR_BIT_RST;
      end else if (wr && paddr == `CVR_ADDR_MASTER) begin
         globalEn_r <= pwdata[`CVR_MASTER_GLOBAL];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         periphEn_r <= `CVR_BIT_RST;
      end else if (wr && paddr == `CVR_ADDR_MASTER) begin
         periphEn_r <= pwdata[`CVR_MASTER_PERIPH];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinAnalogCfg <= `CVR_ANACFG_RST;
      end else if (wr && paddr == `CVR_ADDR_ANACFG) begin
         pinAnalogCfg <= pwdata[`CVR_ANACFG_HI:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= `CVR_BIT_RST;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // The pin-side copies lag their fields by one clock.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpModeSel     <= `CVR_MODE_OFF;
         cmpInputSwitch <= `CVR_BIT_RST;
      end else begin
         cmpModeSel     <= mode_r;
         cmpInputSwitch <= inSwitch_r;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ladderPowerEn  <= `CVR_BIT_RST;
         ladderPinOutEn <= `CVR_BIT_RST;
      end else begin
         ladderPowerEn  <= refPwr_r;
         ladderPinOutEn <= refPinOe_r;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ladderRangeSel  <= `CVR_BIT_RST;
         ladderSourceSel <= `CVR_BIT_RST;
         ladderLevelCode <= `CVR_LEVEL_RST;
      end else begin
         ladderRangeSel  <= refRange_r;
         ladderSourceSel <= refSrc_r;
         ladderLevelCode <= refLevel_r;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmpIrqReq <= `CVR_BIT_RST;
      end else begin
         cmpIrqReq <= irqAll;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wakeReq <= `CVR_BIT_RST;
      end else begin
         wakeReq <= wakeAll;
      end
   end

endmodule // cvr_comparator_ctrl

module cvr_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;

   assign dout = stage2_r;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_r <= {WIDTH{1'b0}};
         stage2_r <= {WIDTH{1'b0}};
      end else begin
         stage1_r <= din;
         stage2_r <= stage1_r;
      end
   end

endmodule // cvr_sync2

/* sim/cvr_chk.sv */
`timescale 1ns/1ps
module cvr_chk (
   input wire logic clk, rst_b, psel, penable, pwrite, pready, pslverr, sleepMode,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic ladderPowerEn, ladderPinOutEn, ladderRangeSel, ladderSourceSel,
   input wire logic cmpIrqReq, wakeReq,
   input wire logic [2:0] cmpModeSel,
   input wire logic [3:0] ladderLevelCode, pinAnalogCfg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire wrDone = psel && penable && pready && pwrite;
   wire [7:0] refOut = {ladderPowerEn, ladderPinOutEn, ladderRangeSel, ladderSourceSel,
                        ladderLevelCode};
   AST_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   AST_PULSE: assert property (pready |=> !pready) else $error("ready held");
   AST_RST_MODE: assert property ($rose(rst_b) |-> cmpModeSel == 3'h7)
      else $error("mode not off after reset");
   AST_RST_REF: assert property ($rose(rst_b) |-> refOut == 8'h00)
      else $error("reference not cleared");
   AST_REF_WR: assert property (
      wrDone && paddr == 12'h004 |=> refOut == $past(pwdata[7:0]))
      else $error("reference outputs wrong");
   AST_CFG: assert property (wrDone && paddr == 12'h014 |-> pinAnalogCfg == pwdata[3:0])
      else $error("pin config wrong");
   AST_WAKE: assert property (cmpIrqReq && $past(sleepMode) |-> wakeReq)
      else $error("no wake");
   AST_WAKE_SLP: assert property (wakeReq |-> $past(sleepMode))
      else $error("wake while awake");
   AST_ERR: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("bad error answer");
   cover property (wakeReq);
   cover property (cmpIrqReq);
   cover property (pslverr);
endmodule // cvr_chk
bind cvr_comparator_ctrl cvr_chk u_chk (.*);

/* sim/cvr_cmp_model.sv */
`timescale 1ns/1ps
module cvr_cmp_model (
   input  wire logic [1:0] want,
   output logic            cmpARaw,
   output logic            cmpBRaw
);
   // The analog outputs move a few ns after the request, unrelated to any clock edge.
   assign #3 {cmpBRaw, cmpARaw} = want;
endmodule // cvr_cmp_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst_b, psel, penable, pwrite, sleepMode, pready, pslverr, er;
   logic        cmpARaw, cmpBRaw, cmpInputSwitch, cmpIrqReq, wakeReq;
   logic        ladderPowerEn, ladderPinOutEn, ladderRangeSel, ladderSourceSel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  cmpModeSel;
   logic [3:0]  ladderLevelCode, pinAnalogCfg;
   logic [1:0]  want;
   logic [7:0]  vals [3] = '{8'hFF, 8'h5A, 8'hA5};
   int          n_fail, n_tests, cyc;
   cvr_comparator_ctrl DUT (.*);
   cvr_cmp_model u_cmp (.*);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd, e);
   endtask
   initial begin
      {psel, penable, pwrite, sleepMode, paddr, pwdata, want} = '0;
      rst_b = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1;
      rdchk(12'h000, 32'h07);
      rdchk(12'h004, 32'h00);
      rdchk(12'h014, 32'h00);
      chk(cmpModeSel, 32'h7);
      apb(1, 12'h014, 32'h0A);
      rdchk(12'h014, 32'h0A);
      foreach (vals[i]) begin
         apb(1, 12'h004, {24'h0, vals[i]});
         rdchk(12'h004, {24'h0, vals[i]});
         chk({ladderPowerEn, ladderPinOutEn, ladderRangeSel, ladderSourceSel, ladderLevelCode}, vals[i]);
      end
      want <= 2'b01;
      repeat (6) @(posedge clk);
      rdchk(12'h008, 32'h40);
      chk(cmpIrqReq, 0);
      apb(1, 12'h008, 32'h0);
      rdchk(12'h008, 32'h40);
      rdchk(12'h000, 32'h47);
      apb(1, 12'h008, 32'h0);
      rdchk(12'h008, 32'h00);
      apb(1, 12'h00C, 32'h40);
      apb(1, 12'h010, 32'hC0);
      apb(1, 12'h008, 32'h40);
      repeat (2) @(posedge clk);
      chk(cmpIrqReq, 1);
      apb(1, 12'h008, 32'h0);
      sleepMode <= 1;
      want <= 2'b11;
      repeat (6) @(posedge clk);
      chk(wakeReq, 1);
      rdchk(12'h000, 32'hC7);
      sleepMode <= 0;
      apb(1, 12'h000, 32'h1A);
      rdchk(12'h000, 32'h9A);
      chk({cmpInputSwitch, cmpModeSel}, 32'hA);
      rdchk(12'h020, 32'h0);
      chk(er, 1);
      wrap_up;
   end
endmodule // tb_top
